// ==== rtl/jtid_pkg.sv ====
// package: constants and types for the test port instruction decoder
package jtid_pkg;

  // ==========================================================
  // instruction register
  localparam int          IR_W       = 16;
  localparam logic [15:0] IR_RST_VAL = 16'h0000;
  localparam logic [15:0] IR_CAP_VAL = 16'h0001;

  // ==========================================================
  // instruction codes
  localparam logic [15:0] OP_EXTEST  = 16'h0000;
  localparam logic [15:0] OP_SAMPLE  = 16'h0002;
  localparam logic [15:0] OP_IDENT   = 16'h0004;
  localparam logic [15:0] OP_BYPASS  = 16'hffff;
  localparam logic [15:0] OP_FL_CTRL = 16'h0082;
  localparam logic [15:0] OP_FL_DATA = 16'h0083;
  localparam logic [15:0] OP_FL_ADDR = 16'h0084;

  // ==========================================================
  // data register widths
  localparam int ID_W  = 32;
  localparam int BYP_W = 1;
  localparam int FC_W  = 8;
  localparam int FD_W  = 20;
  localparam int FA_W  = 20;
  localparam int BSR_W = 134;

  // ==========================================================
  // reset values of held registers
  localparam logic [FC_W-1:0] FC_RST_VAL = 8'h00;
  localparam logic [FD_W-1:0] FD_RST_VAL = 20'h00000;
  localparam logic [FA_W-1:0] FA_RST_VAL = 20'h00000;

  // ==========================================================
  // types
  typedef enum logic [3:0] {
    S_TLR   = 4'h0, S_RTI   = 4'h1, S_SELDR = 4'h2, S_CAPDR = 4'h3,
    S_SHDR  = 4'h4, S_EX1DR = 4'h5, S_PSDR  = 4'h6, S_EX2DR = 4'h7,
    S_UPDR  = 4'h8, S_SELIR = 4'h9, S_CAPIR = 4'ha, S_SHIR  = 4'hb,
    S_EX1IR = 4'hc, S_PSIR  = 4'hd, S_EX2IR = 4'he, S_UPIR  = 4'hf
  } jtid_tap_t;

  typedef enum logic [2:0] {
    D_BSR  = 3'h0, D_IDENT = 3'h1, D_BYP = 3'h2,
    D_FCTL = 3'h3, D_FDAT  = 3'h4, D_FADR = 3'h5
  } jtid_dsel_t;

  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
  } jtid_pins_t;

  typedef struct packed {
    logic [FC_W-1:0] ctrl;
    logic [FD_W-1:0] data;
    logic [FA_W-1:0] addr;
  } jtid_flash_t;

  typedef struct packed {
    logic ctrl;
    logic data;
    logic addr;
  } jtid_fupd_t;

endpackage

// ==== rtl/jtid_top.sv ====
// module: test access port with 16-bit instruction decode
// Notes on behaviour
// - sixteen-bit instruction register, cleared to zero on reset.
// - four pins: clock, mode, data in driven outside; data out driven here.
// - shifting follows the standard test access port state machine.
// - code 0000 picks boundary register with full pin control.
// - code 0002 picks boundary register, observe only: update leaves the pin latches.
// - seven codes; 0004 picks identification, ffff picks bypass.
// - 0082 picks flash control, 0083 picks flash data register.
// - 0084 picks flash address register holding the operation address.
// - three scan registers plus flash registers, all chosen by instruction.
// - identification code is thirty-two bits between data in and out.
// - during external test all inputs to core logic read one.
module jtid_top #(
  parameter int          CORE_W   = 8,
  parameter logic [31:0] IDENT_VAL = 32'h1234_5001  // value arbitrary
) (
  input  wire logic                         ref_clk,
  input  wire logic                         rst,
  input  wire logic                         ce,
  input  wire jtid_pkg::jtid_pins_t         pins,
  output logic                              tdo,
  output logic                              tdo_en_n,
  input  wire logic [jtid_pkg::BSR_W-1:0]   bsr_cap,
  output logic [jtid_pkg::BSR_W-1:0]        bsr_upd,
  output logic                              extest_act,
  input  wire logic [CORE_W-1:0]            core_in_raw,
  output logic [CORE_W-1:0]                 core_in,
  input  wire logic [jtid_pkg::FD_W-1:0]    flash_rdata,
  output jtid_pkg::jtid_flash_t             flash,
  output jtid_pkg::jtid_fupd_t              flash_upd,
  output logic [jtid_pkg::IR_W-1:0]         ir_val
);

  localparam int BW = jtid_pkg::BSR_W;

  // ==========================================================
  // instruction decode
  function automatic jtid_pkg::jtid_dsel_t dec(input logic [15:0] ir);
    case (ir)
      jtid_pkg::OP_EXTEST:  dec = jtid_pkg::D_BSR;
      jtid_pkg::OP_SAMPLE:  dec = jtid_pkg::D_BSR;
      jtid_pkg::OP_IDENT:   dec = jtid_pkg::D_IDENT;
      jtid_pkg::OP_BYPASS:  dec = jtid_pkg::D_BYP;
      jtid_pkg::OP_FL_CTRL: dec = jtid_pkg::D_FCTL;
      jtid_pkg::OP_FL_DATA: dec = jtid_pkg::D_FDAT;
      jtid_pkg::OP_FL_ADDR: dec = jtid_pkg::D_FADR;
      default:              dec = jtid_pkg::D_BYP;
    endcase
  endfunction

  function automatic int dlen(input jtid_pkg::jtid_dsel_t s);
    case (s)
      jtid_pkg::D_BSR:   dlen = jtid_pkg::BSR_W;
      jtid_pkg::D_IDENT: dlen = jtid_pkg::ID_W;
      jtid_pkg::D_FCTL:  dlen = jtid_pkg::FC_W;
      jtid_pkg::D_FDAT:  dlen = jtid_pkg::FD_W;
      jtid_pkg::D_FADR:  dlen = jtid_pkg::FA_W;
      default:           dlen = jtid_pkg::BYP_W;
    endcase
  endfunction

  // ==========================================================
  // pin synchronisers and clock edge detect
  jtid_pkg::jtid_pins_t sy1_r, sy1_nxt, sy2_r, sy2_nxt;
  logic                 tck_d_r, tck_d_nxt;
  logic                 tck_rise, tck_fall;

  always_comb begin
    sy1_nxt   = pins;
    sy2_nxt   = sy1_r;
    tck_d_nxt = sy2_r.tck;
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sy1_r   <= 3'b110;  // clock and mode at idle high: no false rising edge
      sy2_r   <= 3'b110;
      tck_d_r <= 1'b1;
    end else if (ce) begin
      sy1_r   <= sy1_nxt;
      sy2_r   <= sy2_nxt;
      tck_d_r <= tck_d_nxt;
    end
  end

  assign tck_rise = sy2_r.tck & ~tck_d_r;
  assign tck_fall = ~sy2_r.tck & tck_d_r;

  // ==========================================================
  // tap controller and scan registers
  jtid_pkg::jtid_tap_t   tap_r, tap_nxt;
  jtid_pkg::jtid_dsel_t  sel;
  logic [15:0]           ir_r, ir_nxt, irs_r, irs_nxt;
  logic [BW-1:0]         drs_r, drs_nxt, shifted;
  logic [BW-1:0]         bsr_r, bsr_nxt;
  jtid_pkg::jtid_flash_t fl_r, fl_nxt;
  jtid_pkg::jtid_fupd_t  fu_r, fu_nxt;
  logic                  tdo_r, tdo_nxt, ten_r, ten_nxt;
  logic                  ext_r, ext_nxt;
  logic [CORE_W-1:0]     cin_r, cin_nxt;
  int                    len;
  logic                  tms;

  assign sel = dec(ir_r);
  assign len = dlen(sel);
  assign tms = sy2_r.tms;

  always_comb begin
    tap_nxt = tap_r;
    ir_nxt  = ir_r;
    irs_nxt = irs_r;
    drs_nxt = drs_r;
    bsr_nxt = bsr_r;
    fl_nxt  = fl_r;
    fu_nxt  = '0;
    tdo_nxt = tdo_r;
    ten_nxt = ten_r;
    shifted = {1'b0, drs_r[BW-1:1]};
    shifted[len-1] = sy2_r.tdi;
    if (tck_rise) begin
      case (tap_r)
        jtid_pkg::S_TLR:   tap_nxt = tms ? jtid_pkg::S_TLR : jtid_pkg::S_RTI;
        jtid_pkg::S_RTI:   tap_nxt = tms ? jtid_pkg::S_SELDR : jtid_pkg::S_RTI;
        jtid_pkg::S_SELDR: tap_nxt = tms ? jtid_pkg::S_SELIR : jtid_pkg::S_CAPDR;
        jtid_pkg::S_CAPDR: tap_nxt = tms ? jtid_pkg::S_EX1DR : jtid_pkg::S_SHDR;
        jtid_pkg::S_SHDR:  tap_nxt = tms ? jtid_pkg::S_EX1DR : jtid_pkg::S_SHDR;
        jtid_pkg::S_EX1DR: tap_nxt = tms ? jtid_pkg::S_UPDR : jtid_pkg::S_PSDR;
        jtid_pkg::S_PSDR:  tap_nxt = tms ? jtid_pkg::S_EX2DR : jtid_pkg::S_PSDR;
        jtid_pkg::S_EX2DR: tap_nxt = tms ? jtid_pkg::S_UPDR : jtid_pkg::S_SHDR;
        jtid_pkg::S_UPDR:  tap_nxt = tms ? jtid_pkg::S_SELDR : jtid_pkg::S_RTI;
        jtid_pkg::S_SELIR: tap_nxt = tms ? jtid_pkg::S_TLR : jtid_pkg::S_CAPIR;
        jtid_pkg::S_CAPIR: tap_nxt = tms ? jtid_pkg::S_EX1IR : jtid_pkg::S_SHIR;
        jtid_pkg::S_SHIR:  tap_nxt = tms ? jtid_pkg::S_EX1IR : jtid_pkg::S_SHIR;
        jtid_pkg::S_EX1IR: tap_nxt = tms ? jtid_pkg::S_UPIR : jtid_pkg::S_PSIR;
        jtid_pkg::S_PSIR:  tap_nxt = tms ? jtid_pkg::S_EX2IR : jtid_pkg::S_PSIR;
        jtid_pkg::S_EX2IR: tap_nxt = tms ? jtid_pkg::S_UPIR : jtid_pkg::S_SHIR;
        jtid_pkg::S_UPIR:  tap_nxt = tms ? jtid_pkg::S_SELDR : jtid_pkg::S_RTI;
        default:           tap_nxt = jtid_pkg::S_TLR;
      endcase
      case (tap_r)
        jtid_pkg::S_CAPIR: irs_nxt = jtid_pkg::IR_CAP_VAL;
        jtid_pkg::S_SHIR:  irs_nxt = {sy2_r.tdi, irs_r[15:1]};
        jtid_pkg::S_UPIR:  ir_nxt  = irs_r;
        jtid_pkg::S_CAPDR: begin
          drs_nxt = '0;
          case (sel)
            jtid_pkg::D_BSR:   drs_nxt = bsr_cap;
            jtid_pkg::D_IDENT: drs_nxt[31:0] = IDENT_VAL;
            jtid_pkg::D_FCTL:  drs_nxt[jtid_pkg::FC_W-1:0] = fl_r.ctrl;
            jtid_pkg::D_FDAT:  drs_nxt[jtid_pkg::FD_W-1:0] = flash_rdata;
            jtid_pkg::D_FADR:  drs_nxt[jtid_pkg::FA_W-1:0] = fl_r.addr;
            default:           drs_nxt = '0;
          endcase
        end
        jtid_pkg::S_SHDR:  drs_nxt = shifted;
        jtid_pkg::S_UPDR: begin
          case (sel)
            jtid_pkg::D_BSR: begin
              if (ir_r == jtid_pkg::OP_EXTEST) begin
                bsr_nxt = drs_r;
              end
            end
            jtid_pkg::D_FCTL: begin
              fl_nxt.ctrl = drs_r[jtid_pkg::FC_W-1:0];
              fu_nxt.ctrl = 1'b1;
            end
            jtid_pkg::D_FDAT: begin
              fl_nxt.data = drs_r[jtid_pkg::FD_W-1:0];
              fu_nxt.data = 1'b1;
            end
            jtid_pkg::D_FADR: begin
              fl_nxt.addr = drs_r[jtid_pkg::FA_W-1:0];
              fu_nxt.addr = 1'b1;
            end
            default: fu_nxt = '0;
          endcase
        end
        default: irs_nxt = irs_r;
      endcase
    end
    if (tck_fall) begin
      // data out changes on the falling edge only
      ten_nxt = !(tap_r == jtid_pkg::S_SHDR || tap_r == jtid_pkg::S_SHIR);
      tdo_nxt = (tap_r == jtid_pkg::S_SHIR) ? irs_r[0] : drs_r[0];
    end
    if (tap_r == jtid_pkg::S_TLR) begin
      ir_nxt = jtid_pkg::IR_RST_VAL;
    end
    ext_nxt = (ir_r == jtid_pkg::OP_EXTEST);
    cin_nxt = ext_nxt ? '1 : core_in_raw;
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      tap_r <= jtid_pkg::S_TLR;
      ir_r  <= jtid_pkg::IR_RST_VAL;
      irs_r <= jtid_pkg::IR_RST_VAL;
      drs_r <= '0;
      bsr_r <= '0;
      fl_r  <= '{jtid_pkg::FC_RST_VAL, jtid_pkg::FD_RST_VAL,
                 jtid_pkg::FA_RST_VAL};
      fu_r  <= '0;
      tdo_r <= 1'b0;
      ten_r <= 1'b1;
      ext_r <= 1'b0;
      cin_r <= '0;
    end else if (ce) begin
      tap_r <= tap_nxt;
      ir_r  <= ir_nxt;
      irs_r <= irs_nxt;
      drs_r <= drs_nxt;
      bsr_r <= bsr_nxt;
      fl_r  <= fl_nxt;
      fu_r  <= fu_nxt;
      tdo_r <= tdo_nxt;
      ten_r <= ten_nxt;
      ext_r <= ext_nxt;
      cin_r <= cin_nxt;
    end
  end

  assign tdo        = tdo_r;
  assign tdo_en_n   = ten_r;
  assign bsr_upd    = bsr_r;
  assign extest_act = ext_r;
  assign core_in    = cin_r;
  assign flash      = fl_r;
  assign flash_upd  = fu_r;
  assign ir_val     = ir_r;

  // ==========================================================
  // assertions
  logic [jtid_pkg::FD_W-1:0] drs_lo;
  assign drs_lo = drs_r[jtid_pkg::FD_W-1:0];

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  sequence s_upd(jtid_pkg::jtid_dsel_t d);
    ce && tck_rise && tap_r == jtid_pkg::S_UPDR && sel == d;
  endsequence

  property p_ir_tlr;
    ce && tap_r == jtid_pkg::S_TLR |=> ir_r == 16'h0000;
  endproperty
  a_ir_tlr: assert property (p_ir_tlr)
    else $error("instruction not cleared in reset state");

  property p_tap_walk;
    ce && tck_rise && tap_r == jtid_pkg::S_RTI && tms
      |=> tap_r == jtid_pkg::S_SELDR;
  endproperty
  a_tap_walk: assert property (p_tap_walk)
    else $error("tap did not leave idle");

  property p_ir_load;
    ce && tck_rise && tap_r == jtid_pkg::S_UPIR |=> ir_r == $past(irs_r);
  endproperty
  a_ir_load: assert property (p_ir_load)
    else $error("instruction not loaded on update");

  property p_extest;
    ce && ir_r == jtid_pkg::OP_EXTEST |=> extest_act && core_in == '1;
  endproperty
  a_extest: assert property (p_extest)
    else $error("core inputs not forced high in external test");

  property p_sample;
    s_upd(jtid_pkg::D_BSR) ##0 ir_r == jtid_pkg::OP_SAMPLE
      |=> $stable(bsr_upd);
  endproperty
  a_sample: assert property (p_sample)
    else $error("sample drove the pin latches");

  property p_bypass_cap;
    ce && tck_rise && tap_r == jtid_pkg::S_CAPDR && ir_r == 16'hffff
      |=> drs_r[0] == 1'b0;
  endproperty
  a_bypass_cap: assert property (p_bypass_cap)
    else $error("bypass capture not zero");

  property p_ident;
    ce && tck_rise && tap_r == jtid_pkg::S_CAPDR && ir_r == 16'h0004
      |=> drs_r[31:0] == IDENT_VAL;
  endproperty
  a_ident: assert property (p_ident)
    else $error("identification code not captured");

  property p_undef;
    !(ir_r inside {16'h0000, 16'h0002, 16'h0004, 16'hffff,
                   16'h0082, 16'h0083, 16'h0084})
      |-> sel == jtid_pkg::D_BYP;
  endproperty
  a_undef: assert property (p_undef)
    else $error("unknown code not routed to bypass");

  property p_fdata;
    s_upd(jtid_pkg::D_FDAT) |=> flash_upd.data && flash.data == $past(drs_lo);
  endproperty
  a_fdata: assert property (p_fdata)
    else $error("flash data not updated");

  property p_faddr;
    s_upd(jtid_pkg::D_FADR) |=> flash_upd.addr ##1 !flash_upd.addr;
  endproperty
  a_faddr: assert property (p_faddr)
    else $error("flash address update pulse wrong");

  property p_tdo_en;
    ce && tck_fall |=> tdo_en_n == ($past(tap_r) != jtid_pkg::S_SHDR &&
                                    $past(tap_r) != jtid_pkg::S_SHIR);
  endproperty
  a_tdo_en: assert property (p_tdo_en)
    else $error("data out enable wrong around shift");

endmodule

// ==== sim/jtid_ctl_model.sv ====
// file: behavioural model of the external boundary-scan controller
module jtid_ctl_model (
  input  wire logic            ref_clk,
  input  wire logic            tdo,
  output jtid_pkg::jtid_pins_t pins
);
  timeunit 1ns;
  timeprecision 100ps;

  // tck parked low, mode high until the first frame
  initial pins = 3'b010;

  // ==========================================================
  // one tck period of 320 ns, tdo taken late in the high phase
  task automatic bit_clk(input logic tms_v, input logic tdi_v,
                         output logic tdo_v);
    @(posedge ref_clk);
    #1;
    pins = {1'b0, tms_v, tdi_v};
    repeat (4) @(posedge ref_clk);
    #1;
    pins.tck = 1'b1;
    repeat (3) @(posedge ref_clk);
    #1;
    tdo_v = tdo;
  endtask

  // mode sequence, first step in bit 0
  task automatic move(input logic [7:0] seq, input int n);
    logic d;
    for (int i = 0; i < n; i++) begin
      bit_clk(seq[i], 1'b0, d);
    end
  endtask

  // five steps high then one low: reset state, then idle
  task automatic tap_reset();
    move(8'h1f, 6);
  endtask

  // idle to shift, n bits lsb first, update, back to idle
  task automatic scan(input logic ir, input int n,
                      input logic [133:0] v, output logic [133:0] cap);
    logic d;
    cap = '0;
    if (ir) begin
      move(8'h03, 4);
    end else begin
      move(8'h01, 3);
    end
    for (int i = 0; i < n; i++) begin
      bit_clk(i == n - 1, v[i], d);
      cap[i] = d;
    end
    move(8'h01, 2);
  endtask
endmodule

// ==== sim/jtag_instruction_decode_bench.sv ====
// file: self-checking bench for the test port instruction decoder
module jtag_instruction_decode_bench;
  timeunit 1ns;
  timeprecision 100ps;

  localparam logic [31:0]  ID_V = 32'h0a5c_3001; // value arbitrary
  localparam logic [133:0] PAT1 = {6'h2d, {4{32'h9e37_79b9}}};
  localparam logic [133:0] PAT2 = ~PAT1;

  logic                  ref_clk   = 1'b0;
  logic                  rst       = 1'b1;
  logic [133:0]          bsr_cap   = '0;
  logic [7:0]            raw       = 8'h5a;
  logic [19:0]           rdata     = 20'h3c5a1;
  jtid_pkg::jtid_fupd_t  seen      = '0;
  int                    error_cnt = 0;
  int                    n_tests   = 0;
  jtid_pkg::jtid_pins_t  pins;
  jtid_pkg::jtid_flash_t flash;
  jtid_pkg::jtid_fupd_t  upd;
  logic                  tdo;
  logic                  tdo_en_n;
  logic                  extest_act;
  logic [133:0]          bsr_upd;
  logic [133:0]          cap;
  logic [7:0]            core_in;
  logic [15:0]           ir_val;

  always #20 ref_clk = ~ref_clk;
  always @(posedge ref_clk) seen <= seen | upd;

  jtid_top #(.CORE_W(8), .IDENT_VAL(ID_V)) u_dut (
    .ref_clk     (ref_clk),
    .rst         (rst),
    .ce          (1'b1),
    .pins        (pins),
    .tdo         (tdo),
    .tdo_en_n    (tdo_en_n),
    .bsr_cap     (bsr_cap),
    .bsr_upd     (bsr_upd),
    .extest_act  (extest_act),
    .core_in_raw (raw),
    .core_in     (core_in),
    .flash_rdata (rdata),
    .flash       (flash),
    .flash_upd   (upd),
    .ir_val      (ir_val)
  );

  jtid_ctl_model u_ctl (
    .ref_clk (ref_clk),
    .tdo     (tdo),
    .pins    (pins)
  );

  // ==========================================================
  // checking and closing
  task automatic chk(input logic [133:0] got, input logic [133:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic test_done();
    $display("errors=%0d comparisons=%0d", error_cnt, n_tests);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic load(input logic [15:0] c);
    u_ctl.scan(1'b1, 16, 134'(c), cap);
    chk(cap[15:0], 134'h0001);
    chk(ir_val, c);
  endtask

  // ==========================================================
  // scenarios
  task automatic t_reset();
    chk(ir_val, 134'h0);
    chk(tdo_en_n, 134'h1);
    u_ctl.tap_reset();
    load(jtid_pkg::OP_IDENT);
    u_ctl.tap_reset();
    chk(ir_val, 134'h0);
  endtask

  task automatic t_ident();
    load(jtid_pkg::OP_IDENT);
    u_ctl.scan(1'b0, 32, '0, cap);
    chk(cap[31:0], ID_V);
  endtask

  task automatic t_bypass();
    logic [15:0] codes [3] = '{jtid_pkg::OP_BYPASS, 16'h0005, 16'h0081};
    foreach (codes[i]) begin
      load(codes[i]);
      seen = '0;
      u_ctl.scan(1'b0, 4, 134'hb, cap);
      @(posedge ref_clk);
      #1;
      chk(cap[3:0], 134'h6);
      chk(seen, 134'h0);
      chk(bsr_upd, PAT1);
    end
  endtask

  task automatic t_extest();
    bsr_cap = PAT2;
    load(jtid_pkg::OP_EXTEST);
    @(posedge ref_clk);
    #1;
    chk(extest_act, 134'h1);
    chk(core_in, 134'hff);
    u_ctl.scan(1'b0, 134, PAT1, cap);
    chk(cap, PAT2);
    chk(bsr_upd, PAT1);
  endtask

  task automatic t_sample();
    @(posedge ref_clk);
    #1;
    bsr_cap = PAT1;
    load(jtid_pkg::OP_SAMPLE);
    @(posedge ref_clk);
    #1;
    chk(extest_act, 134'h0);
    chk(core_in, 134'h5a);
    u_ctl.scan(1'b0, 134, PAT2, cap);
    chk(cap, PAT1);
    chk(bsr_upd, PAT1);
  endtask

  task automatic t_flash();
    logic [15:0] c [3] = '{16'h0082, 16'h0083, 16'h0084};
    int          w [3] = '{8, 20, 20};
    int          sh [3] = '{40, 20, 0};
    logic [19:0] v [3] = '{20'h000a5, 20'h5c3e1, 20'h0f00f};
    foreach (c[i]) begin
      load(c[i]);
      seen = '0;
      u_ctl.scan(1'b0, w[i], 134'(v[i]), cap);
      @(posedge ref_clk);
      #1;
      chk(seen, 134'(3'b100 >> i));
      chk((134'(flash) >> sh[i]) & ((134'h1 << w[i]) - 1), v[i]);
      if (i == 1) begin
        chk(cap[19:0], rdata);
      end
    end
  endtask

  // ==========================================================
  // main sequence and watchdog
  initial begin
    repeat (12) @(posedge ref_clk);
    #1;
    rst = 1'b0;
    repeat (4) @(posedge ref_clk);
    #1;
    t_reset();
    t_ident();
    t_extest();
    t_sample();
    t_bypass();
    t_flash();
    // mid-run reset, then the reset scenario again
    rst = 1'b1;
    repeat (2) @(posedge ref_clk);
    #1;
    rst = 1'b0;
    repeat (4) @(posedge ref_clk);
    #1;
    t_reset();
    test_done();
  end

  initial begin
    repeat (20000) @(posedge ref_clk);
    error_cnt++;
    test_done();
  end
endmodule
